// >>> src/ioc_pkg.sv
// Package of register map, reset values, timing constants and types for the terminal conditioner.
package ioc_pkg;
    // Clock rate and the derived tick and gate counts.
    localparam int unsigned CLK_HZ = 200000000;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned TICK_STD_PS = 1000000000;   // 1 ms standard tick.
    localparam int unsigned TICK_FAST_PS = 500000;       // 0.5 us fast tick.
    localparam int unsigned TICK_STD_CYC = TICK_STD_PS / CLK_PERIOD_PS;
    localparam int unsigned TICK_FAST_CYC = TICK_FAST_PS / CLK_PERIOD_PS;
    localparam int unsigned GATE_MS = 1000;              // Frequency gate of one second.
    localparam int unsigned GATE_CYC = GATE_MS * (CLK_HZ / 1000);
    localparam logic [31:0] NCO_HALF = 32'h05F5E100;     // Half the clock rate in Hz.
    localparam logic [33:0] PCT_FULL = 34'h000002710;    // 100.00 percent in 0.01 steps.
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_FILT_A = 8'h04;
    localparam logic [7:0] OFS_PMIN_A = 8'h08;
    localparam logic [7:0] OFS_PMAX_A = 8'h0C;
    localparam logic [7:0] OFS_CTRL_B = 8'h10;
    localparam logic [7:0] OFS_POUT_B = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_PVAL_A = 8'h1C;
    localparam logic [7:0] OFS_FREQ_A = 8'h20;
    localparam logic [7:0] OFS_FREQ_B = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h2C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h30;
    // Field positions.
    localparam int unsigned POS_INV = 0;
    localparam int unsigned POS_FAST = 1;
    localparam int unsigned POS_TRIG = 2;
    localparam int unsigned POS_FT = 0;
    localparam int unsigned POS_ST = 8;
    localparam int unsigned POS_MODE = 0;
    localparam int unsigned POS_LVL = 4;
    // Values after reset.
    localparam logic [6:0] RST_FAST_T = 7'h00;           // 0.00 us.
    localparam logic [6:0] RST_STD_T = 7'h05;            // 5 ms.
    localparam logic [16:0] RST_PMIN = 17'h00000;        // 0 Hz.
    localparam logic [16:0] RST_PMAX = 17'h1ADB0;        // 110000 Hz.
    localparam logic [16:0] PFREQ_LIM = 17'h1ADB0;       // Upper bound of the minimum and maximum frequency settings.
    // Modes of the bidirectional terminal and edge trigger selections.
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0, MODE_DOUT = 3'h1, MODE_POUT = 3'h2, MODE_DIN = 3'h3, MODE_PIN = 3'h4
    } ioc_mode_t;
    localparam ioc_mode_t RST_MODE = MODE_DIN;
    typedef enum logic [1:0] {
        TRIG_NONE = 2'h0, TRIG_RISE = 2'h1, TRIG_FALL = 2'h2, TRIG_BOTH = 2'h3
    } ioc_trig_t;
    // Settings of both terminals as one carrier.
    typedef struct packed {
        logic inv;
        logic fast;
        ioc_trig_t trig;
        logic [6:0] fast_t;
        logic [6:0] std_t;
        logic [16:0] pmin;
        logic [16:0] pmax;
        ioc_mode_t mode;
        logic lvl;
        logic [16:0] pout;
    } ioc_cfg_t;
    localparam int unsigned NIRQ = 3;
endpackage : ioc_pkg

// >>> src/ioc_terminal_conditioner.sv
// Terminal conditioner: input filtering, edge events, pulse metering and pulse output.
//
// Notes on behaviour
// - Inversion 0 passes input, 1 inverts.
// - Fast filter time 0 to 63.5 us.
// - Standard filter time 0 to 127 ms, default 5.
// - Reaction 0 ticks 1 ms, 1 ticks 0.5 us.
// - Trigger none, rising, falling or both edges.
// - Minimum pulse frequency maps to 0 percent.
// - Maximum pulse frequency maps to 100 percent.
// - Mode 1 digital output, mode 0 inactive.
// - Mode 2 drives a frequency-encoded pulse output.
// - Mode 3, the default, is digital input.
// - Mode 4 measures input pulse frequency.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ioc_terminal_conditioner
    import ioc_pkg::*;
#(
    parameter int unsigned STD_TICK = TICK_STD_CYC,
    parameter int unsigned GATE = GATE_CYC
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Terminal pins.
    input wire logic term_a_in,
    input wire logic term_b_in,
    output logic term_b_out,
    output logic term_b_oe,
    // Interrupt.
    output logic irq
);
    // Settings, bus state and read data.
    ioc_cfg_t cfg_q, cfg_d;
    logic wr_q, wr_d;
    logic [7:0] adr_q, adr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [NIRQ-1:0] ist_q, ist_d, ien_q, ien_d;
    // Synchronisers: stage one is read only by stage two.
    logic [1:0] a_s1_q, a_s2_q;
    // Filter and edge state.
    logic filt_q, filt_d;
    logic [17:0] pre_q, pre_d;
    logic [6:0] cnt_q, cnt_d;
    logic b_prev_q, b_prev_d;
    // Frequency meters and pulse value.
    logic [27:0] gate_q, gate_d;
    logic [19:0] ecnt_q [2];
    logic [19:0] ecnt_d [2];
    logic [19:0] freq_q [2];
    logic [19:0] freq_d [2];
    logic [1:0] prev_q, prev_d;
    logic [13:0] pval_q, pval_d;
    // Pulse output oscillator.
    logic [31:0] acc_q, acc_d;
    logic pout_q, pout_d;
    // Combinational helpers.
    logic cond_a, gate_end, trig_ev, b_edge;
    logic [NIRQ-1:0] ev;
    logic [1:0] src;

    // Decides whether the bidirectional terminal is currently an input.
    function automatic logic is_input(input ioc_mode_t m);
        is_input = (m == MODE_DIN) || (m == MODE_PIN);
    endfunction : is_input

    // The slave never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign irq = |(ist_q & ien_q);

    // Pin drive per terminal mode; the pin floats when inactive or an input.
    always_comb begin
        term_b_oe = 1'b0;
        term_b_out = 1'b0;
        case (cfg_q.mode)
            MODE_DOUT: begin
                term_b_oe = 1'b1;
                term_b_out = cfg_q.lvl;
            end
            MODE_POUT: begin
                term_b_oe = 1'b1;
                term_b_out = pout_q;
            end
            default: begin
                term_b_oe = 1'b0;
            end
        endcase
    end

    // Two flip-flop synchronisers for both terminal pins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_s1_q <= 2'h0;
            a_s2_q <= 2'h0;
        end else begin
            a_s1_q <= {term_b_in, term_a_in};
            a_s2_q <= a_s1_q;
        end
    end

    // Conditioned input A after optional inversion.
    assign cond_a = a_s2_q[0] ^ cfg_q.inv;

    // Debounce filter: the tick base follows the reaction setting, and the
    // output changes only once the input has differed for the whole time.
    always_comb begin
        pre_d = pre_q + 18'h00001;
        cnt_d = cnt_q;
        filt_d = filt_q;
        if ((cfg_q.fast && pre_q >= 18'(TICK_FAST_CYC - 1)) ||
            (!cfg_q.fast && pre_q >= 18'(STD_TICK - 1))) begin
            pre_d = 18'h00000;
        end
        if (cond_a == filt_q) begin
            cnt_d = 7'h00;
        end else if (cnt_q >= (cfg_q.fast ? cfg_q.fast_t : cfg_q.std_t)) begin
            filt_d = cond_a;
            cnt_d = 7'h00;
        end else if (pre_d == 18'h00000) begin
            cnt_d = cnt_q + 7'h01;
        end
    end

    // Edge events on the filtered input and on input B.
    always_comb begin
        case (cfg_q.trig)
            TRIG_RISE: trig_ev = filt_d && !filt_q;
            TRIG_FALL: trig_ev = !filt_d && filt_q;
            TRIG_BOTH: trig_ev = filt_d != filt_q;
            default: trig_ev = 1'b0;
        endcase
        b_prev_d = a_s2_q[1];
        b_edge = is_input(cfg_q.mode) && (a_s2_q[1] != b_prev_q);
    end

    // Registers of the filter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_q <= 1'b0;
            pre_q <= 18'h00000;
            cnt_q <= 7'h00;
            b_prev_q <= 1'b0;
        end else begin
            filt_q <= filt_d;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            b_prev_q <= b_prev_d;
        end
    end

    // Frequency meters count rising edges over a fixed gate; B counts only in
    // pulse input mode. Counts saturate so a runaway input cannot wrap.
    assign gate_end = (gate_q >= 28'(GATE - 1));
    assign src = {a_s2_q[1] && (cfg_q.mode == MODE_PIN), a_s2_q[0]};
    always_comb begin
        gate_d = gate_end ? 28'h0000000 : gate_q + 28'h0000001;
        prev_d = src;
        pval_d = pval_q;
        for (int i = 0; i < 2; i++) begin
            ecnt_d[i] = ecnt_q[i];
            freq_d[i] = freq_q[i];
            if (src[i] && !prev_q[i] && ecnt_q[i] != 20'hFFFFF) begin
                ecnt_d[i] = ecnt_q[i] + 20'h00001;
            end
            if (gate_end) begin
                freq_d[i] = ecnt_d[i];
                ecnt_d[i] = 20'h00000;
            end
        end
        // Linear mapping between the two frequency settings, clamped.
        if (gate_end) begin
            if (freq_d[0] >= 20'(cfg_q.pmax)) begin
                pval_d = 14'(PCT_FULL);
            end else if (freq_d[0] <= 20'(cfg_q.pmin)) begin
                pval_d = 14'h0000;
            end else begin
                pval_d = 14'((34'(freq_d[0] - 20'(cfg_q.pmin)) * PCT_FULL) /
                             34'(cfg_q.pmax - cfg_q.pmin));
            end
        end
    end

    // Registers of the meters.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_q <= 28'h0000000;
            prev_q <= 2'h0;
            pval_q <= 14'h0000;
            for (int i = 0; i < 2; i++) begin
                ecnt_q[i] <= 20'h00000;
                freq_q[i] <= 20'h00000;
            end
        end else begin
            gate_q <= gate_d;
            prev_q <= prev_d;
            pval_q <= pval_d;
            ecnt_q <= ecnt_d;
            freq_q <= freq_d;
        end
    end

    // Pulse output oscillator: a square wave at the set frequency in Hz,
    // toggled each time the accumulator passes half the clock rate.
    always_comb begin
        acc_d = acc_q + 32'(cfg_q.pout);
        pout_d = pout_q;
        if (cfg_q.mode != MODE_POUT) begin
            acc_d = 32'h00000000;
            pout_d = 1'b0;
        end else if (acc_d >= NCO_HALF) begin
            acc_d = acc_d - NCO_HALF;
            pout_d = !pout_q;
        end
    end

    // Registers of the oscillator.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 32'h00000000;
            pout_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            pout_q <= pout_d;
        end
    end

    // Events feeding the sticky status bits.
    assign ev = {b_edge, gate_end, trig_ev};

    // Bus slave: address phase latched, read data registered in the address
    // phase so it stands in the data phase with no wait state.
    always_comb begin
        cfg_d = cfg_q;
        ien_d = ien_q;
        ist_d = ist_q;
        wr_d = hsel && hready && htrans[1] && hwrite;
        adr_d = hsel && hready && htrans[1] ? haddr[7:0] : adr_q;
        rdata_d = 32'h00000000;
        if (wr_q) begin
            if (adr_q == OFS_CTRL_A) begin
                cfg_d.inv = hwdata[POS_INV];
                cfg_d.fast = hwdata[POS_FAST];
                cfg_d.trig = ioc_trig_t'(hwdata[POS_TRIG +: 2]);
            end else if (adr_q == OFS_FILT_A) begin
                cfg_d.fast_t = hwdata[POS_FT +: 7];
                cfg_d.std_t = hwdata[POS_ST +: 7];
            end else if (adr_q == OFS_PMIN_A) begin
                cfg_d.pmin = hwdata[16:0] > PFREQ_LIM ? PFREQ_LIM : hwdata[16:0];
            end else if (adr_q == OFS_PMAX_A) begin
                cfg_d.pmax = hwdata[16:0] > PFREQ_LIM ? PFREQ_LIM : hwdata[16:0];
            end else if (adr_q == OFS_CTRL_B) begin
                // Unlisted mode codes are refused and the old mode stays.
                if (hwdata[POS_MODE +: 3] <= 3'(MODE_PIN)) begin
                    cfg_d.mode = ioc_mode_t'(hwdata[POS_MODE +: 3]);
                end
                cfg_d.lvl = hwdata[POS_LVL];
            end else if (adr_q == OFS_POUT_B) begin
                cfg_d.pout = hwdata[16:0];
            end else if (adr_q == OFS_IRQ_CLR) begin
                ist_d = ist_q & ~hwdata[NIRQ-1:0];
            end else if (adr_q == OFS_IRQ_EN) begin
                ien_d = hwdata[NIRQ-1:0];
            end
        end
        // A new event wins over a clear in the same cycle.
        ist_d = ist_d | ev;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == OFS_CTRL_A) begin
                rdata_d = 32'({cfg_q.trig, cfg_q.fast, cfg_q.inv});
            end else if (haddr[7:0] == OFS_FILT_A) begin
                rdata_d = 32'({1'b0, cfg_q.std_t, 1'b0, cfg_q.fast_t});
            end else if (haddr[7:0] == OFS_PMIN_A) begin
                rdata_d = 32'(cfg_q.pmin);
            end else if (haddr[7:0] == OFS_PMAX_A) begin
                rdata_d = 32'(cfg_q.pmax);
            end else if (haddr[7:0] == OFS_CTRL_B) begin
                rdata_d = 32'({cfg_q.lvl, 1'b0, cfg_q.mode});
            end else if (haddr[7:0] == OFS_POUT_B) begin
                rdata_d = 32'(cfg_q.pout);
            end else if (haddr[7:0] == OFS_STAT) begin
                rdata_d = 32'({term_b_out, a_s2_q[1], filt_q});
            end else if (haddr[7:0] == OFS_PVAL_A) begin
                rdata_d = 32'(pval_q);
            end else if (haddr[7:0] == OFS_FREQ_A) begin
                rdata_d = 32'(freq_q[0]);
            end else if (haddr[7:0] == OFS_FREQ_B) begin
                rdata_d = 32'(freq_q[1]);
            end else if (haddr[7:0] == OFS_IRQ_STAT) begin
                rdata_d = 32'(ist_q);
            end else if (haddr[7:0] == OFS_IRQ_EN) begin
                rdata_d = 32'(ien_q);
            end
        end
    end

    // Registers of the bus slave and settings.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= '{inv: 1'b0, fast: 1'b0, trig: TRIG_NONE, fast_t: RST_FAST_T,
                       std_t: RST_STD_T, pmin: RST_PMIN, pmax: RST_PMAX,
                       mode: RST_MODE, lvl: 1'b0, pout: 17'h00000};
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            rdata_q <= 32'h00000000;
            ist_q <= '0;
            ien_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            wr_q <= wr_d;
            adr_q <= adr_d;
            rdata_q <= rdata_d;
            ist_q <= ist_d;
            ien_q <= ien_d;
        end
    end
endmodule : ioc_terminal_conditioner
`default_nettype wire

// >>> dv/ioc_properties.sv
// Checker of bus and terminal behaviour seen at the conditioner's ports.
`timescale 1ns/1ps
`default_nettype none
module ioc_properties
    import ioc_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins and interrupt.
    input wire logic term_a_in,
    input wire logic term_b_in,
    input wire logic term_b_out,
    input wire logic term_b_oe,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take; // Address phase accepted in this cycle.
    logic rd_q, wb_q, we_q; // Data phase of a read, a mode write, an enable write.
    logic [7:0] ofs_q; // Offset of the transfer now in its data phase.
    logic [2:0] mode_q, en_q; // Shadows of the terminal mode and the interrupt enables.
    logic lvl_q; // Shadow of the output level.
    assign take = hsel && hready && htrans[1];
    // Shadows follow the writes, so pin checks need no view inside the block.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wb_q, we_q, ofs_q, mode_q, en_q, lvl_q} <= {3'h0, 8'h00, 3'h3, 3'h0, 1'h0};
        end else begin
            rd_q <= take && !hwrite;
            wb_q <= take && hwrite && haddr[7:0] == OFS_CTRL_B;
            we_q <= take && hwrite && haddr[7:0] == OFS_IRQ_EN;
            ofs_q <= haddr[7:0];
            // Codes 5 to 7 are refused and leave the mode as it was.
            if (wb_q && hwdata[2:0] <= 3'h4) mode_q <= hwdata[2:0];
            if (wb_q) lvl_q <= hwdata[POS_LVL];
            if (we_q) en_q <= hwdata[2:0];
        end
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not zero");
    a_clr_reads_zero: assert property (rd_q && ofs_q == OFS_IRQ_CLR |-> hrdata == 32'h0)
        else $error("clear register read not zero");
    a_unmapped_zero: assert property (rd_q && ofs_q > OFS_IRQ_EN |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_dout_level: assert property (mode_q == 3'h1 |-> term_b_oe && term_b_out == lvl_q)
        else $error("digital output level wrong");
    a_quiet_modes: assert property (mode_q inside {3'h0, 3'h3, 3'h4} |-> !term_b_oe)
        else $error("terminal driven in a non-output mode");
    a_pout_drives: assert property (mode_q == 3'h2 |-> term_b_oe)
        else $error("pulse output not driven");
    a_irq_masked: assert property (en_q == 3'h0 |-> !irq) else $error("irq with no enable");
    c_dout: cover property (mode_q == 3'h1 && term_b_out);
    c_pout: cover property (mode_q == 3'h2 && $rose(term_b_out));
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (rd_q && ofs_q > OFS_IRQ_EN);
endmodule : ioc_properties
`default_nettype wire

// >>> dv/ioc_field_model.sv
// Field device model: drives both terminal pins and reads back the driven one.
`timescale 1ns/1ps
`default_nettype none
module ioc_field_model (
    // Clock of the pulse generators.
    input wire logic hclk,
    // Commands: level, and pulse period in cycles (zero for a steady level).
    input wire logic a_lvl,
    input wire logic [15:0] a_per,
    input wire logic b_lvl,
    input wire logic [15:0] b_per,
    // Terminal B as the block drives it.
    input wire logic term_b_out,
    input wire logic term_b_oe,
    // Pins seen by the block.
    output logic term_a_in,
    output logic term_b_in
);
    logic [15:0] a_cnt = 16'h0; // Position within the pulse period of A.
    logic [15:0] b_cnt = 16'h0; // Position within the pulse period of B.
    // Free-running period counters; a square wave is high in the first half.
    always_ff @(posedge hclk) begin
        a_cnt <= (a_cnt + 16'h1 >= a_per) ? 16'h0 : a_cnt + 16'h1;
        b_cnt <= (b_cnt + 16'h1 >= b_per) ? 16'h0 : b_cnt + 16'h1;
    end
    assign term_a_in = (a_per == 16'h0) ? a_lvl : (a_cnt < a_per / 2);
    // While the block drives B the field side lets go, so the wire carries the block's value.
    assign term_b_in = term_b_oe ? term_b_out : ((b_per == 16'h0) ? b_lvl : (b_cnt < b_per / 2));
endmodule : ioc_field_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the terminal conditioner over its bus and pins.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ioc_pkg::*;
;
    localparam int GATE_T = 1000; // Shortened meter gate, in cycles.
    localparam int LIMIT = 40000; // Cycle ceiling of the whole run.
    typedef struct {logic [31:0] v; logic [31:0] m; int t;} ioc_exp_t; // Value, mask, tolerance.
    localparam logic [7:0] RA [9] = '{OFS_CTRL_A, OFS_FILT_A, OFS_PMIN_A, OFS_PMAX_A, OFS_CTRL_B,
        OFS_POUT_B, OFS_IRQ_EN, OFS_IRQ_CLR, 8'h40};
    localparam logic [31:0] RV [9] = '{32'h0, 32'h500, 32'h0, 32'h1ADB0, 32'h3, 32'h0, 32'h0,
        32'h0, 32'h0};
    // Meter cases: minimum, maximum, expected value, tolerance (100 counts per gate).
    localparam logic [31:0] MT [4][4] = '{'{32'h0, 32'hC8, 32'h1388, 32'h32},
        '{32'h32, 32'h96, 32'h1388, 32'h64}, '{32'h0, 32'h32, 32'h2710, 32'h0},
        '{32'h96, 32'h12C, 32'h0, 32'h0}};
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_dp = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, term_a_in, term_b_in, term_b_out, term_b_oe, irq;
    logic a_lvl = 1'h0, b_lvl = 1'h0;
    logic [15:0] a_per = 16'h0, b_per = 16'h0;
    ioc_exp_t expq[$]; // Notes of expected read words, oldest first.
    int checks = 0, miscompares = 0, cyc = 0, n, seed = 32'h6244227F;
    always #2.5 hclk = ~hclk;
    ioc_terminal_conditioner #(.STD_TICK(20), .GATE(GATE_T)) ioc_terminal_conditioner_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .term_a_in(term_a_in),
        .term_b_in(term_b_in), .term_b_out(term_b_out), .term_b_oe(term_b_oe), .irq(irq));
    ioc_field_model ioc_field_model_i (.hclk(hclk), .a_lvl(a_lvl), .a_per(a_per),
        .b_lvl(b_lvl), .b_per(b_per), .term_b_out(term_b_out), .term_b_oe(term_b_oe),
        .term_a_in(term_a_in), .term_b_in(term_b_in));
    // Compare one result; a tolerance accepts a window around a measured count.
    task automatic cmp(input logic [31:0] got, input ioc_exp_t e);
        logic ok;
        checks++;
        ok = (e.t == 0) ? ((got & e.m) === (e.v & e.m))
            : ((^got !== 1'hX) && got + e.t >= e.v && got <= e.v + e.t);
        if (!ok) begin
            miscompares++;
            $display("BAD at %0t: got %h, expected %h", $time, got, e.v);
        end
    endtask : cmp
    // Check a single pin level.
    task automatic pin(input logic p, input logic v);
        cmp({31'h0, p}, '{{31'h0, v}, 32'h1, 0});
    endtask : pin
    // One transfer: address phase held until accepted, then the data phase until accepted.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask : wr
    // A read leaves its expectation in the queue; the monitor settles it.
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = '1,
        input int t = 0);
        expq.push_back('{v, m, t});
        xfer(1'h0, a, 32'h0);
    endtask : rd
    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Read data are taken at the edge ending the data phase, against the oldest note.
    always @(posedge hclk) begin
        if (rd_dp && expq.size() > 0) cmp(hrdata, expq.pop_front());
        rd_dp = hsel && hreadyout && htrans[1] && !hwrite;
    end
    // A hang is cut short and counted as a mismatch.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        wr(8'h40, 32'hFFFFFFFF);
        for (int i = 0; i < 9; i++) rd(RA[i], RV[i]);
        // Standard reaction, default time of five ticks.
        a_lvl <= 1'h1;
        repeat (50) @(posedge hclk);
        rd(OFS_STAT, 32'h0, 32'h1);
        repeat (150) @(posedge hclk);
        rd(OFS_STAT, 32'h1, 32'h1);
        // Fast reaction, four ticks of the short base.
        wr(OFS_CTRL_A, 32'h2);
        wr(OFS_FILT_A, 32'h4);
        a_lvl <= 1'h0;
        repeat (250) @(posedge hclk);
        rd(OFS_STAT, 32'h1, 32'h1);
        repeat (500) @(posedge hclk);
        rd(OFS_STAT, 32'h0, 32'h1);
        wr(OFS_FILT_A, 32'h0);
        wr(OFS_CTRL_A, 32'h3);
        repeat (10) @(posedge hclk);
        rd(OFS_STAT, 32'h1, 32'h1);
        for (int t = 0; t < 4; t++) begin
            wr(OFS_CTRL_A, 32'h2 | (t << POS_TRIG));
            wr(OFS_IRQ_EN, 32'h1);
            wr(OFS_IRQ_CLR, 32'h7);
            a_lvl <= 1'h1;
            repeat (10) @(posedge hclk);
            rd(OFS_IRQ_STAT, t & 1, 32'h1);
            pin(irq, t[0]);
            wr(OFS_IRQ_CLR, 32'h1);
            a_lvl <= 1'h0;
            repeat (10) @(posedge hclk);
            rd(OFS_IRQ_STAT, t >> 1, 32'h1);
            wr(OFS_IRQ_EN, 32'h0);
            @(posedge hclk);
            pin(irq, 1'h0);
            wr(OFS_IRQ_CLR, 32'h1);
            wr(OFS_IRQ_EN, 32'h1);
            @(posedge hclk);
            pin(irq, 1'h0);
        end
        // Random settings; values above the limit are clamped.
        repeat (4) begin
            r = $random(seed) & 32'h1FFFF;
            wr(OFS_PMAX_A, r);
            rd(OFS_PMAX_A, (r > 32'h1ADB0) ? 32'h1ADB0 : r);
            r = $random(seed);
            wr(OFS_FILT_A, r);
            rd(OFS_FILT_A, r & 32'h7F7F);
        end
        a_per <= 16'h000A;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_PMIN_A, MT[i][0]);
            wr(OFS_PMAX_A, MT[i][1]);
            repeat (2 * GATE_T + 20) @(posedge hclk);
            rd(OFS_PVAL_A, MT[i][2], '1, MT[i][3]);
        end
        rd(OFS_FREQ_A, 32'h64, '1, 1);
        a_per <= 16'h0;
        wr(OFS_CTRL_B, 32'h11);
        @(posedge hclk);
        pin(term_b_out, 1'h1);
        pin(term_b_oe, 1'h1);
        wr(OFS_CTRL_B, 32'h01);
        rd(OFS_STAT, 32'h0, 32'h4);
        wr(OFS_POUT_B, 32'h186A0);
        wr(OFS_CTRL_B, 32'h2);
        n = 0;
        repeat (10000) begin
            r[0] = term_b_out;
            @(posedge hclk);
            n += (term_b_out !== r[0]);
        end
        cmp(n, '{32'hA, '1, 1});
        wr(OFS_CTRL_B, 32'h0);
        @(posedge hclk);
        pin(term_b_oe, 1'h0);
        wr(OFS_CTRL_B, 32'h3);
        wr(OFS_IRQ_EN, 32'h4);
        wr(OFS_IRQ_CLR, 32'h7);
        b_lvl <= 1'h1;
        repeat (10) @(posedge hclk);
        rd(OFS_STAT, 32'h2, 32'h2);
        pin(irq, 1'h1);
        wr(OFS_CTRL_B, 32'h4);
        b_per <= 16'h0014;
        repeat (2 * GATE_T + 20) @(posedge hclk);
        rd(OFS_FREQ_B, 32'h32, '1, 1);
        wr(OFS_CTRL_B, 32'h7);
        rd(OFS_CTRL_B, 32'h4, 32'h7);
        // Let the monitor settle the last read, and count any note left unanswered.
        repeat (2) @(posedge hclk);
        if (expq.size() != 0) miscompares++;
        give_verdict();
    end
endmodule : testbench
bind ioc_terminal_conditioner ioc_properties ioc_properties_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .term_a_in(term_a_in), .term_b_in(term_b_in), .term_b_out(term_b_out),
    .term_b_oe(term_b_oe), .irq(irq));
`default_nettype wire
